/* rtl/sdpc_pkg.sv */
/*
  Shared definitions of the regulator-off and multipurpose pin configuration bank:
  register offsets, field positions, reset values, bus carriers and state types.
  Assumes a single 200 MHz APB clock domain and an active-low asynchronous reset.
*/
package sdpc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned SDPC_ADDR_W = 12;
  localparam int unsigned SDPC_DATA_W = 32;
  localparam int unsigned SDPC_PIN_N = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [SDPC_ADDR_W-1:0] SDPC_OFF_SHUT = 12'h000;
  localparam logic [SDPC_ADDR_W-1:0] SDPC_OFF_PIN0 = 12'h004;
  localparam logic [SDPC_ADDR_W-1:0] SDPC_OFF_PIN1 = 12'h008;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SDPC_SHUT_LINEAR_POS = 2;
  localparam int unsigned SDPC_SHUT_SWITCH_POS = 0;
  localparam int unsigned SDPC_PIN_POL_POS = 5;
  localparam int unsigned SDPC_PIN_KIND_POS = 3;
  localparam int unsigned SDPC_PIN_ROLE_POS = 0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SDPC_KIND_HIGHZ = 2'h0;
  localparam logic [1:0] SDPC_KIND_OPEN_DRAIN = 2'h1;
  localparam logic [2:0] SDPC_ROLE_OFF = 3'h0;
  localparam logic [1:0] SDPC_SW_FORCED_PWM = 2'h0;
  localparam logic [1:0] SDPC_SW_PFM_PWM = 2'h1;
  localparam logic [1:0] SDPC_SW_RES_SLEW = 2'h2;
  localparam logic [1:0] SDPC_SW_RES_RC = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic linear;
    logic [1:0] switching;
  } sdpc_shut_cfg_t;

  typedef struct packed {
    logic polarity;
    logic [1:0] driver_kind;
    logic [2:0] role;
  } sdpc_pin_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [SDPC_ADDR_W-1:0] paddr;
    logic [SDPC_DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } sdpc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [SDPC_DATA_W-1:0] prdata;
    logic pslverr;
  } sdpc_apb_rsp_t;

  typedef enum logic [1:0] {
    SDPC_SEL_SHUT,
    SDPC_SEL_PIN0,
    SDPC_SEL_PIN1,
    SDPC_SEL_NONE
  } sdpc_sel_t;

  typedef struct packed {
    sdpc_shut_cfg_t shut;
    sdpc_pin_cfg_t [SDPC_PIN_N-1:0] pin;
    sdpc_apb_rsp_t rsp;
  } sdpc_top_state_t;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
    logic delays_used;
  } sdpc_pin_state_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam sdpc_shut_cfg_t SDPC_SHUT_RESET = 3'h2;
  localparam sdpc_pin_cfg_t SDPC_PIN_RESET = 6'h0d;
  localparam sdpc_apb_rsp_t SDPC_RSP_RESET = '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};
  localparam sdpc_top_state_t SDPC_TOP_RESET = '{
    shut: SDPC_SHUT_RESET,
    pin: {SDPC_PIN_RESET, SDPC_PIN_RESET},
    rsp: SDPC_RSP_RESET
  };
  localparam sdpc_pin_state_t SDPC_PIN_STATE_RESET = 3'h0;

endpackage

/* rtl/sdpc_pin.sv */
/*
  Output stage of one multipurpose pin: applies polarity, driver kind and role
  to the sequencer's assert request and tells the sequencer whether to use delays.
  Assumes the request comes from logic on the same clock.
*/
module sdpc_pin (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdpc_pkg::sdpc_pin_cfg_t cfg,
  input wire logic assert_req,
  output logic pin_o,
  output logic pin_oe,
  output logic delays_used
);
  import sdpc_pkg::*;

  sdpc_pin_state_t st_r;
  sdpc_pin_state_t st_nxt;
  logic enabled;
  logic level;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    enabled = (cfg.role != SDPC_ROLE_OFF);
    level = (enabled && assert_req) ? cfg.polarity : ~cfg.polarity;
    st_nxt.delays_used = enabled;
    case (cfg.driver_kind)
      SDPC_KIND_HIGHZ: begin
        st_nxt.pin_o = 1'b0;
        st_nxt.pin_oe = 1'b0;
      end
      SDPC_KIND_OPEN_DRAIN: begin
        st_nxt.pin_o = 1'b0;
        st_nxt.pin_oe = enabled && !level;
      end
      default: begin
        st_nxt.pin_o = level;
        st_nxt.pin_oe = enabled;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SDPC_PIN_STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_o = st_r.pin_o;
  assign pin_oe = st_r.pin_oe;
  assign delays_used = st_r.delays_used;

endmodule // sdpc_pin

/* rtl/sdpc_top.sv */
/*
  APB register bank for the regulator-off methods and two multipurpose pins,
  with the pin output stages and the decoded controls for the power sequencer.
  Assumes an APB master on pclk and a sequencer on the same clock.
*/
// The implementer's own choices: the register addresses and register access over APB.
//
// Behaviour
// - One bit picks resistor discharge at off slew rate or RC rate for linear regulators.
// - Two bits pick forced PWM, PFM/PWM, resistor slew or resistor RC for switchers.
// - Polarity bit clear makes the asserted pin level low, set makes it high.
// - Driver kind 01 drives open drain: pulls low only, never drives high.
// - Role 000 disables the pin and its on/off delays are ignored.
module sdpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdpc_pkg::sdpc_apb_req_t apb_req,
  output sdpc_pkg::sdpc_apb_rsp_t apb_rsp,
  input wire logic [sdpc_pkg::SDPC_PIN_N-1:0] multipurpose_pin_n_assert,
  output logic [sdpc_pkg::SDPC_PIN_N-1:0] multipurpose_pin_n_o,
  output logic [sdpc_pkg::SDPC_PIN_N-1:0] multipurpose_pin_n_oe,
  output logic [sdpc_pkg::SDPC_PIN_N-1:0] multipurpose_pin_n_delays_used,
  output logic linear_reg_off_method,
  output logic [1:0] switch_reg_off_method,
  output logic [2:0] pin_zero_role,
  output logic [2:0] pin_one_role
);
  import sdpc_pkg::*;

  sdpc_top_state_t st_r;
  sdpc_top_state_t st_nxt;
  sdpc_sel_t sel;
  logic access;
  logic done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic sdpc_sel_t sdpc_decode(input logic [SDPC_ADDR_W-1:0] addr);
    sdpc_sel_t s;
    case (addr)
      SDPC_OFF_SHUT: s = SDPC_SEL_SHUT;
      SDPC_OFF_PIN0: s = SDPC_SEL_PIN0;
      SDPC_OFF_PIN1: s = SDPC_SEL_PIN1;
      default: s = SDPC_SEL_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [SDPC_DATA_W-1:0] sdpc_read(input sdpc_sel_t s, input sdpc_top_state_t st);
    logic [SDPC_DATA_W-1:0] d;
    case (s)
      SDPC_SEL_SHUT: d = {29'h0000_0000, st.shut};
      SDPC_SEL_PIN0: d = {26'h000_0000, st.pin[0]};
      SDPC_SEL_PIN1: d = {26'h000_0000, st.pin[1]};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic sdpc_pin_cfg_t sdpc_pin_wr(input logic [SDPC_DATA_W-1:0] d);
    sdpc_pin_cfg_t c;
    c.polarity = d[SDPC_PIN_POL_POS];
    c.driver_kind = d[SDPC_PIN_KIND_POS +: 2];
    c.role = d[SDPC_PIN_ROLE_POS +: 3];
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sel = sdpc_decode(apb_req.paddr);
    access = apb_req.psel && apb_req.penable;
    done = access && st_r.rsp.pready;
    // One wait state: pready rises in the second access cycle
    st_nxt.rsp.pready = access && !st_r.rsp.pready;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata = 32'h0000_0000;
    if (access && !st_r.rsp.pready) begin
      st_nxt.rsp.pslverr = (sel == SDPC_SEL_NONE);
      if (!apb_req.pwrite) begin
        st_nxt.rsp.prdata = sdpc_read(sel, st_r);
      end
    end
    if (done && apb_req.pwrite && apb_req.pstrb[0]) begin
      case (sel)
        SDPC_SEL_SHUT: begin
          st_nxt.shut.linear = apb_req.pwdata[SDPC_SHUT_LINEAR_POS];
          st_nxt.shut.switching = apb_req.pwdata[SDPC_SHUT_SWITCH_POS +: 2];
        end
        SDPC_SEL_PIN0: begin
          st_nxt.pin[0] = sdpc_pin_wr(apb_req.pwdata);
        end
        SDPC_SEL_PIN1: begin
          st_nxt.pin[1] = sdpc_pin_wr(apb_req.pwdata);
        end
        default: begin
          st_nxt.shut = st_r.shut;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SDPC_TOP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp = st_r.rsp;
  assign linear_reg_off_method = st_r.shut.linear;
  assign switch_reg_off_method = st_r.shut.switching;
  assign pin_zero_role = st_r.pin[0].role;
  assign pin_one_role = st_r.pin[1].role;

  // ----------------------------------------------------------------
  // Pin output stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < SDPC_PIN_N; i++) begin : g_pin
    sdpc_pin u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(st_r.pin[i]),
      .assert_req(multipurpose_pin_n_assert[i]),
      .pin_o(multipurpose_pin_n_o[i]),
      .pin_oe(multipurpose_pin_n_oe[i]),
      .delays_used(multipurpose_pin_n_delays_used[i])
    );
  end

endmodule // sdpc_top

/* testbench/sdpc_top_sva.sv */
/* Checker of sdpc_top: bus timing, register outputs and pin stage relations.
   Assumes one clock pclk and the active-low reset presetn. */
module sdpc_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdpc_pkg::sdpc_apb_req_t apb_req,
  input wire sdpc_pkg::sdpc_apb_rsp_t apb_rsp,
  input wire logic [1:0] multipurpose_pin_n_assert,
  input wire logic [1:0] multipurpose_pin_n_o,
  input wire logic [1:0] multipurpose_pin_n_oe,
  input wire logic [1:0] multipurpose_pin_n_delays_used,
  input wire logic linear_reg_off_method,
  input wire logic [1:0] switch_reg_off_method,
  input wire logic [2:0] pin_zero_role,
  input wire logic [2:0] pin_one_role
);
  import sdpc_pkg::*;
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire wr_shut = done && apb_req.pwrite && apb_req.paddr == SDPC_OFF_SHUT && apb_req.pstrb[0];
  wire mapped = apb_req.paddr inside {SDPC_OFF_SHUT, SDPC_OFF_PIN0, SDPC_OFF_PIN1};
  sequence s_access;
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
  endsequence
  a_one_wait: assert property (s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not in second access cycle");
  a_linear_write: assert property (
    wr_shut |=> linear_reg_off_method == $past(apb_req.pwdata[2])) else $error("linear method not written");
  a_switch_write: assert property (
    wr_shut |=> switch_reg_off_method == $past(apb_req.pwdata[1:0])) else $error("switch method not written");
  a_role_on: assert property (
    pin_zero_role != SDPC_ROLE_OFF |=> multipurpose_pin_n_delays_used[0]) else $error("delays not used");
  a_role_off: assert property (
    pin_zero_role == SDPC_ROLE_OFF |=> !multipurpose_pin_n_delays_used[0] && !multipurpose_pin_n_oe[0])
    else $error("disabled pin still active");
  a_pin_one_off: assert property (
    pin_one_role == SDPC_ROLE_OFF |=> !multipurpose_pin_n_delays_used[1]) else $error("pin one delays used");
  a_read_upper: assert property (
    done && !apb_req.pwrite |-> apb_rsp.prdata[31:6] == 0) else $error("upper bits not zero");
  a_unmapped: assert property (done && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == 0)
    else $error("unmapped access not refused");
endmodule // sdpc_top_sva

bind sdpc_top sdpc_top_sva chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .multipurpose_pin_n_assert(multipurpose_pin_n_assert), .multipurpose_pin_n_o(multipurpose_pin_n_o),
  .multipurpose_pin_n_oe(multipurpose_pin_n_oe), .multipurpose_pin_n_delays_used(multipurpose_pin_n_delays_used),
  .linear_reg_off_method(linear_reg_off_method), .switch_reg_off_method(switch_reg_off_method),
  .pin_zero_role(pin_zero_role), .pin_one_role(pin_one_role));

/* testbench/sdpc_top_tb.sv */
/* Testbench of sdpc_top: register access over the bus and pin stage outputs.
   Assumes the package and the design are compiled first. */
module sdpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdpc_pkg::*;
  // ----------
  // Stimulus
  // ----------
  logic pclk = 0;
  logic presetn = 0;
  sdpc_apb_req_t rq = '0;
  sdpc_apb_rsp_t rs;
  logic [1:0] as = '0;
  logic [1:0] po, poe, pd, sw;
  logic lin, e;
  logic [2:0] r0, r1;
  logic [31:0] q;
  int err_count = 0;
  int comparisons = 0;
  always #2.5 pclk = ~pclk;
  sdpc_top uut (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs), .multipurpose_pin_n_assert(as),
    .multipurpose_pin_n_o(po), .multipurpose_pin_n_oe(poe), .multipurpose_pin_n_delays_used(pd),
    .linear_reg_off_method(lin), .switch_reg_off_method(sw), .pin_zero_role(r0), .pin_one_role(r1));
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    int n = 0;
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge pclk);
    rq.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rs.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("[ERR] pready expected 1 seen %b", rs.pready);
      final_report();
    end
    q = rs.prdata;
    e = rs.pslverr;
    rq <= '0;
    @(posedge pclk);
  endtask
  function automatic logic [2:0] exp_pin(logic [5:0] c, logic a);
    logic on, l;
    on = c[2:0] != 0;
    l = (on & a) ? c[5] : ~c[5];
    if (c[4:3] == 2'h0) return {2'h0, on};
    if (c[4:3] == 2'h1) return {1'b0, on & ~l, on};
    return {l, on, on};
  endfunction
  task automatic t_reset();
    apb(0, SDPC_OFF_SHUT, 0, 4'hf);
    chk("shut_rst", 32'h2, q);
    chk("ok_flag", 0, e);
    apb(0, SDPC_OFF_PIN0, 0, 4'hf);
    chk("pin0_rst", 32'hd, q);
    apb(0, SDPC_OFF_PIN1, 0, 4'hf);
    chk("pin1_rst", 32'hd, q);
    chk("roles_rst", 32'h2d, {r0, r1});
    $display("t_reset done");
  endtask
  task automatic t_rerst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, SDPC_OFF_SHUT, 0, 4'hf);
    chk("shut_rerst", 32'h2, q);
    apb(0, SDPC_OFF_PIN0, 0, 4'hf);
    chk("pin0_rerst", 32'hd, q);
    chk("roles_rerst", 32'h2d, {r0, r1});
    $display("t_rerst done");
  endtask
  task automatic t_shut();
    for (int i = 0; i < 8; i++) begin
      apb(1, SDPC_OFF_SHUT, 32'hffff_fff8 | i, 4'hf);
      apb(0, SDPC_OFF_SHUT, 0, 4'hf);
      chk("shut_rd", i, q);
      chk("shut_out", i, {lin, sw});
    end
    $display("t_shut done");
  endtask
  task automatic t_pins();
    logic [11:0] ad;
    for (int p = 0; p < 2; p++) begin
      ad = p ? SDPC_OFF_PIN1 : SDPC_OFF_PIN0;
      for (int c = 0; c < 64; c++) begin
        apb(1, ad, 32'hffff_ffc0 | c, 4'hf);
        apb(0, ad, 0, 4'hf);
        chk("pin_rd", c, q);
        chk("role", c[2:0], p ? r1 : r0);
        for (int a = 0; a < 2; a++) begin
          as[p] <= a[0];
          @(posedge pclk);
          @(posedge pclk);
          chk("pin", exp_pin(c[5:0], a[0]), {po[p], poe[p], pd[p]});
        end
      end
      apb(0, p ? SDPC_OFF_PIN0 : SDPC_OFF_PIN1, 0, 4'hf);
      chk("other_pin", p ? 32'h3f : 32'hd, q);
    end
    $display("t_pins done");
  endtask
  task automatic t_err();
    apb(0, 12'h00c, 0, 4'hf);
    chk("err_flag", 1, e);
    chk("err_data", 0, q);
    apb(1, 12'h001, 0, 4'hf);
    chk("err_wr", 1, e);
    apb(1, SDPC_OFF_SHUT, 32'h5, 4'h0);
    apb(0, SDPC_OFF_SHUT, 0, 4'hf);
    chk("no_strobe", 32'h7, q);
    $display("t_err done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_shut();
    t_pins();
    t_err();
    t_rerst();
    final_report();
  end
endmodule // sdpc_top_tb
